// ==== rtl/bit_field_defs.vh ====
// Constants for the bit-field unit: register map, instruction word layout,
// status flag positions and reset values. Definitions only.
// Assumes inclusion by bare name from every design file that needs them.
//
// Notes on behaviour
// - Sign-fill insert extends the inserted field; bits below it keep background.
// - Insert and pull set nil and neg flags, clear carry, overflow.
// - Insert and pull accept the parallel-issue mark of the command word.
// - Pull and interleave are taken only from a long (32-bit) command word.
// - Pull copies L bits from position p of source into result LSBs.
// - Pull control: position in bits 12..8, length in bits 4..0.
// - Pull reads bits above source MSB as zero when p plus L exceeds 32.
// - Pull leaves both sources unchanged; result lands in its own register.
// - Pull fills above field with zeros, or with field top bit.
// - Interleave writes back both sources and the accumulator.
// - Right interleave feeds first then second source LSB into accumulator MSB.
// - Right interleave: accumulator moves two places, sources one, zero enters.
// - Left interleave feeds second then first source MSB into accumulator LSB.
// - Left interleave: sources move left one, zero enters; accumulator two.
// - Insert foreground is upper half; position 12..8, length 4..0 up to 16.
// - Insert overwrites L background bits at p; zero length passes background for plain insert.
`ifndef BIT_FIELD_DEFS_VH
`define BIT_FIELD_DEFS_VH

// Register byte offsets
`define REG_COMMAND      8'h00
`define REG_OPERAND_A    8'h04
`define REG_OPERAND_B    8'h08
`define REG_RESULT       8'h0C
`define REG_ACC_LOW      8'h10
`define REG_ACC_HIGH     8'h14
`define REG_STATUS       8'h18

// Command word fields
`define CMD_OP_MSB       3
`define CMD_OP_LSB       0
`define CMD_PARALLEL_BIT 30
`define CMD_LONG_BIT     31
`define OP_INSERT        4'h1
`define OP_INSERT_SIGN   4'h2
`define OP_PULL_ZERO     4'h3
`define OP_PULL_SIGN     4'h4
`define OP_MUX_RIGHT     4'h5
`define OP_MUX_LEFT      4'h6

// Control field positions inside the operand register
`define POS_MSB          12
`define POS_LSB          8
`define LEN_MSB          4
`define LEN_LSB          0
`define INSERT_MAX_LEN   5'h10

// Status flag positions and width
`define FLAG_NIL         0
`define FLAG_NEG         1
`define FLAG_CARRY       2
`define FLAG_OVF         3
`define FLAG_REFUSED     8
`define STATUS_W         9
`define STATUS_RESET     9'h000

// Accumulator
`define ACC_W            40
`define ACC_HIGH_W       8

// AXI responses
`define RESP_OKAY        2'h0
`define RESP_DECERR      2'h3

`endif

// ==== rtl/field_merge.v ====
// Combinational insert and pull datapath for 32-bit data words.
// Assumes operands are held stable by the caller for the cycle of use.
`timescale 1ns/100ps
`include "bit_field_defs.vh"

module field_merge (
  input  wire [31:0] background,
  input  wire [31:0] control,
  input  wire        insertSign,
  input  wire        pullSign,
  output reg  [31:0] insertResult,
  output reg  [31:0] pullResult
);

  // Ones in the n lowest places; n of 32 or more gives all ones
  function [31:0] lowMask;
    input [5:0] n;
    begin
      lowMask = (n >= 6'd32) ? 32'hFFFFFFFF : ((32'h00000001 << n) - 32'h00000001);
    end
  endfunction

  reg [4:0]  pos;
  reg [4:0]  len;
  reg [5:0]  top;
  reg [31:0] mask;
  reg [31:0] merged;
  reg [31:0] shifted;
  reg        signBit;

  // Lengths above 16 are outside the legal range and are clamped
  always @* begin
    pos = control[`POS_MSB:`POS_LSB];
    len = control[`LEN_MSB:`LEN_LSB];
    if (len > `INSERT_MAX_LEN)
      len = `INSERT_MAX_LEN;
    top = {1'b0, pos} + {1'b0, len};
    mask = lowMask({1'b0, len}) << pos;
    merged = (background & ~mask) | (({16'h0000, control[31:16]} << pos) & mask);
    shifted = merged >> (top - 6'd1);
    // Sign comes from the field top, or background below p when L is 0
    signBit = (top == 6'd0) ? 1'b0 : shifted[0];
    if (!insertSign || top >= 6'd32)
      insertResult = merged;
    else
      insertResult = (merged & lowMask(top)) | ({32{signBit}} & ~lowMask(top));
  end

  reg [31:0] scene;
  reg [31:0] field;
  reg [31:0] fieldTop;

  // Logical shift brings zeros in above the source MSB
  always @* begin
    scene = background >> control[`POS_MSB:`POS_LSB];
    field = scene & lowMask({1'b0, control[`LEN_MSB:`LEN_LSB]});
    fieldTop = scene >> (control[`LEN_MSB:`LEN_LSB] - 5'd1);
    if (pullSign && control[`LEN_MSB:`LEN_LSB] != 5'd0 && fieldTop[0])
      pullResult = field | ~lowMask({1'b0, control[`LEN_MSB:`LEN_LSB]});
    else
      pullResult = field;
  end

endmodule // field_merge

// ==== rtl/bit_interleave.v ====
// Combinational two-bit interleave of two data words into a wide accumulator.
// Assumes the two sources come from different registers.
`timescale 1ns/100ps
`include "bit_field_defs.vh"

module bit_interleave #(
  parameter ACC_W = `ACC_W
) (
  input  wire [31:0]      firstSource,
  input  wire [31:0]      secondSource,
  input  wire [ACC_W-1:0] accIn,
  input  wire             shiftLeft,
  output reg  [31:0]      firstOut,
  output reg  [31:0]      secondOut,
  output reg  [ACC_W-1:0] accOut
);

  // Right: first LSB lands one below second LSB at the top
  always @* begin
    if (shiftLeft) begin
      accOut = {accIn[ACC_W-3:0], secondSource[31], firstSource[31]};
      firstOut = {firstSource[30:0], 1'b0};
      secondOut = {secondSource[30:0], 1'b0};
    end else begin
      accOut = {secondSource[0], firstSource[0], accIn[ACC_W-1:2]};
      firstOut = {1'b0, firstSource[31:1]};
      secondOut = {1'b0, secondSource[31:1]};
    end
  end

endmodule // bit_interleave

// ==== rtl/bit_field_unit.v ====
// Bit-field unit: insert, pull and interleave on software-loaded operands,
// reached as an AXI4-Lite slave. A write to the command register runs one
// operation in the same cycle the write is committed.
// Assumes a single AXI4-Lite master, one write and one read in flight.
`timescale 1ns/100ps
`include "bit_field_defs.vh"

module bit_field_unit #(
  parameter ACC_W = `ACC_W
) (
  input  wire        clock,
  input  wire        rst_b,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  // Byte lanes with a strobe take the new data, the rest keep the old
  function [31:0] laneMerge;
    input [31:0] oldWord;
    input [31:0] newWord;
    input [3:0]  strobe;
    integer i;
    begin
      laneMerge = oldWord;
      for (i = 0; i < 4; i = i + 1)
        if (strobe[i])
          laneMerge[i*8 +: 8] = newWord[i*8 +: 8];
    end
  endfunction

  // Known word addresses; anything else is answered with a decode error
  function mapped;
    input [7:0] addr;
    begin
      case ({addr[7:2], 2'b00})
        `REG_COMMAND, `REG_OPERAND_A, `REG_OPERAND_B, `REG_RESULT,
        `REG_ACC_LOW, `REG_ACC_HIGH, `REG_STATUS: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  endfunction

  // Software-visible state
  reg [31:0]          operandA;
  reg [31:0]          operandB;
  reg [31:0]          result;
  reg [ACC_W-1:0]     wideAccumulator;
  reg [`STATUS_W-1:0] arithStatusWord;

  // Write channel capture
  reg        addrHeld;
  reg        dataHeld;
  reg [7:0]  writeAddr;
  reg [31:0] writeData;
  reg [3:0]  writeStrobe;

  // A write commits once both halves are in and no response is pending
  wire       commit   = addrHeld && dataHeld && !s_axi_bvalid;
  wire [7:0] wordAddr = {writeAddr[7:2], 2'b00};
  wire       cmdWrite = commit && (wordAddr == `REG_COMMAND);

  // Command word: unwritten lanes read as zero, so a word without lane 0 runs nothing
  wire [31:0] command  = laneMerge(32'h00000000, writeData, writeStrobe);
  wire [3:0]  opcode   = command[`CMD_OP_MSB:`CMD_OP_LSB];
  wire        longWord = command[`CMD_LONG_BIT];
  wire        parallel = command[`CMD_PARALLEL_BIT];

  // Opcode decode
  wire isInsert = (opcode == `OP_INSERT) || (opcode == `OP_INSERT_SIGN);
  wire isPull   = (opcode == `OP_PULL_ZERO) || (opcode == `OP_PULL_SIGN);
  wire isMux    = (opcode == `OP_MUX_RIGHT) || (opcode == `OP_MUX_LEFT);

  // Insert and pull may carry the parallel mark; interleave may not
  wire pairable  = isInsert || isPull;
  wire needsLong = isPull || isMux;
  wire accepted  = (isInsert || isPull || isMux)
                && !(needsLong && !longWord)
                && !(parallel && !pairable);
  wire refused   = cmdWrite && !accepted;

  wire runField = cmdWrite && accepted && (isInsert || isPull);
  wire runMux   = cmdWrite && accepted && isMux;

  wire [31:0]      insertResult;
  wire [31:0]      pullResult;
  wire [31:0]      firstOut;
  wire [31:0]      secondOut;
  wire [ACC_W-1:0] accOut;

  // Operand A is the background, scene and first source;
  // operand B is the control word and second source.
  field_merge fieldPath (
    .background   (operandA),
    .control      (operandB),
    .insertSign   (opcode == `OP_INSERT_SIGN),
    .pullSign     (opcode == `OP_PULL_SIGN),
    .insertResult (insertResult),
    .pullResult   (pullResult)
  );

  // Sources live in two fixed registers, so they can never alias
  bit_interleave #(
    .ACC_W (ACC_W)
  ) muxPath (
    .firstSource  (operandA),
    .secondSource (operandB),
    .accIn        (wideAccumulator),
    .shiftLeft    (opcode == `OP_MUX_LEFT),
    .firstOut     (firstOut),
    .secondOut    (secondOut),
    .accOut       (accOut)
  );

  wire [31:0] fieldResult = isInsert ? insertResult : pullResult;

  // Write address channel
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      addrHeld <= 1'b0;
      writeAddr <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      addrHeld <= 1'b1;
      writeAddr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (commit) begin
      addrHeld <= 1'b0;
    end else begin
      s_axi_awready <= !addrHeld && !s_axi_bvalid;
    end
  end

  // Write data channel
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dataHeld <= 1'b0;
      writeData <= 32'h00000000;
      writeStrobe <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      dataHeld <= 1'b1;
      writeData <= s_axi_wdata;
      writeStrobe <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (commit) begin
      dataHeld <= 1'b0;
    end else begin
      s_axi_wready <= !dataHeld && !s_axi_bvalid;
    end
  end

  // Write response follows the commit by one edge
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= mapped(writeAddr) ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Operand registers: software writes, or interleave write-back
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      operandA <= 32'h00000000;
      operandB <= 32'h00000000;
    end else if (runMux) begin
      operandA <= firstOut;
      operandB <= secondOut;
    end else if (commit && wordAddr == `REG_OPERAND_A) begin
      operandA <= laneMerge(operandA, writeData, writeStrobe);
    end else if (commit && wordAddr == `REG_OPERAND_B) begin
      operandB <= laneMerge(operandB, writeData, writeStrobe);
    end
  end

  // Result has its own register, so field ops never disturb the operands
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      result <= 32'h00000000;
    else if (runField)
      result <= fieldResult;
  end

  // Wide accumulator: low word and high byte are separately writable
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wideAccumulator <= {ACC_W{1'b0}};
    end else if (runMux) begin
      wideAccumulator <= accOut;
    end else if (commit && wordAddr == `REG_ACC_LOW) begin
      wideAccumulator[31:0] <= laneMerge(wideAccumulator[31:0], writeData, writeStrobe);
    end else if (commit && wordAddr == `REG_ACC_HIGH && writeStrobe[0]) begin
      wideAccumulator[ACC_W-1:32] <= writeData[ACC_W-33:0];
    end
  end

  // Status word. Field ops touch only the four arithmetic flags; the
  // refused mark is sticky and a hardware set wins over a software write.
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      arithStatusWord <= `STATUS_RESET;
    end else begin
      if (commit && wordAddr == `REG_STATUS && writeStrobe[0])
        arithStatusWord[7:0] <= writeData[7:0];
      if (commit && wordAddr == `REG_STATUS && writeStrobe[1])
        arithStatusWord[`FLAG_REFUSED] <= writeData[`FLAG_REFUSED];
      if (runField) begin
        arithStatusWord[`FLAG_NIL] <= (fieldResult == 32'h00000000);
        arithStatusWord[`FLAG_NEG] <= fieldResult[31];
        arithStatusWord[`FLAG_CARRY] <= 1'b0;
        arithStatusWord[`FLAG_OVF] <= 1'b0;
      end
      if (refused)
        arithStatusWord[`FLAG_REFUSED] <= 1'b1;
    end
  end

  // Read data selection
  reg [31:0] readWord;

  always @* begin
    case ({s_axi_araddr[7:2], 2'b00})
      `REG_COMMAND:   readWord = 32'h00000000;
      `REG_OPERAND_A: readWord = operandA;
      `REG_OPERAND_B: readWord = operandB;
      `REG_RESULT:    readWord = result;
      `REG_ACC_LOW:   readWord = wideAccumulator[31:0];
      `REG_ACC_HIGH:  readWord = {24'h000000, wideAccumulator[ACC_W-1:32]};
      `REG_STATUS:    readWord = {23'h000000, arithStatusWord};
      default:        readWord = 32'h00000000;
    endcase
  end

  // Read channel: data registered one edge after the address is taken
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= readWord;
      s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

endmodule // bit_field_unit

// ==== bench/axi_lite_host.sv ====
// AXI4-Lite master model standing in for software on the register bus.
// Assumes one slave; one write and one read at most in flight.
`timescale 1ns/100ps

module axi_lite_host (
  input  wire logic        clock,
  output logic      [7:0]  awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic      [31:0] wdata,
  output logic      [3:0]  wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic      [7:0]  araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    wstrb = 4'hF;
  end

  // Released lines flip so a stale value never looks valid
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clock);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  // Read holds rready until data arrives
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clock);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule // axi_lite_host

// ==== bench/bit_field_unit_properties.sv ====
// Handshake timing and read data checks on the register bus of the bit-field unit.
// Assumes a master that never overlaps two writes or two reads.
`timescale 1ns/100ps

module bit_field_unit_properties (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  // Sequences: answer taken, then ready comes back two edges later
  sequence s_bDone; s_axi_bvalid && s_axi_bready; endsequence
  sequence s_wReopen; !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready); endsequence
  sequence s_rDone; s_axi_rvalid && s_axi_rready; endsequence
  sequence s_rReopen; !s_axi_rvalid ##1 s_axi_arready; endsequence
  sequence s_rTake; s_axi_arvalid && s_axi_arready; endsequence

  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rHold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_wTake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  property p_rTake; s_rTake |=> s_axi_rvalid; endproperty
  property p_wBlock; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  property p_rBlock; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_wReopen; s_bDone |=> s_wReopen; endproperty
  property p_rReopen; s_rDone |=> s_rReopen; endproperty
  property p_decErr;
    s_rTake and s_axi_araddr == 8'h40 |=> s_axi_rresp == 2'h3 && s_axi_rdata == 32'h0;
  endproperty
  property p_statusTop; s_rTake and s_axi_araddr == 8'h18 |=> s_axi_rdata[31:9] == 23'h0;
  endproperty

  a_bHold: assert property (p_bHold) else $error("write response dropped early");
  a_rHold: assert property (p_rHold) else $error("read data changed before taken");
  a_wTake: assert property (p_wTake) else $error("write response not on commit edge");
  a_rTake: assert property (p_rTake) else $error("read data not one cycle after address");
  a_wBlock: assert property (p_wBlock) else $error("write taken while response pending");
  a_rBlock: assert property (p_rBlock) else $error("read taken while data pending");
  a_wReopen: assert property (p_wReopen) else $error("write ready not back in time");
  a_rReopen: assert property (p_rReopen) else $error("read ready not back in time");
  a_decErr: assert property (p_decErr) else $error("unmapped read not refused");
  a_statusTop: assert property (p_statusTop) else $error("status upper bits not zero");
endmodule // bit_field_unit_properties

bind bit_field_unit bit_field_unit_properties u_props (
  .clock(clock), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);

// ==== bench/bit_field_unit_tb.sv ====
// Self-checking bench: operations run through register writes and reads.
// Assumes the register map and command layout of the unit's defines header.
`timescale 1ns/100ps
`include "bit_field_defs.vh"
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin errTotal++; $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end

module bit_field_unit_tb;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  wire  [7:0]  awaddr, araddr;
  wire  [31:0] wdata, rdata;
  wire  [3:0]  wstrb;
  wire  [1:0]  bresp, rresp;
  wire         awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  integer      errTotal = 0;
  integer      nCompared = 0;
  integer      cycles = 0;
  integer      i, j, k;
  logic [31:0] sa, sb, res, ctl [6];
  logic [39:0] acc;

  bit_field_unit u_dut (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  axi_lite_host u_host (.clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // Clock and hang guard; the ceiling is far above the thousand or so cycles needed
  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errTotal++;
      summarize();
    end
  end

  task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic [1:0] r;
    u_host.write(a, d, r);
    `CHK(r, er)
  endtask
  task automatic get(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    u_host.read(a, d, r);
    `CHK(d, e)
    `CHK(r, er)
  endtask

  // Expected pull: bits past the source top read as zero
  function automatic logic [31:0] pullExp(input logic [31:0] s, c, input logic sg);
    logic [63:0] w;
    int          l;
    l = c[4:0];
    w = {32'h0, s} >> c[12:8];
    pullExp = w[31:0] & ~(32'hFFFFFFFF << l);
    if (sg && l > 0 && w[l-1]) pullExp = pullExp | (32'hFFFFFFFF << l);
  endfunction
  // Expected insert: length clamps at 16, sign fill from the field top
  function automatic logic [31:0] insExp(input logic [31:0] b, c, input logic sg);
    int p, l, n;
    p = c[12:8];
    l = (c[4:0] > 16) ? 16 : c[4:0];
    insExp = b;
    for (n = 0; n < l; n++) if (p + n < 32) insExp[p+n] = c[16+n];
    if (sg && p + l == 0) insExp = 32'h0;
    else if (sg) for (n = p + l; n < 32; n++) insExp[n] = insExp[p+l-1];
  endfunction

  // One insert or pull with flags preset so clearing shows
  task automatic fieldOp(input logic [3:0] op, input logic [31:0] e);
    res = e;
    put(`REG_STATUS, 32'hFF);
    put(`REG_COMMAND, {2'b11, 26'h0, op});
    get(`REG_RESULT, e);
    get(`REG_STATUS, {24'h0, 4'hF, 2'b00, e[31], e == 32'h0});
    get(`REG_OPERAND_A, sa);
    get(`REG_OPERAND_B, sb);
  endtask

  task summarize;
    $display("compared %0d mismatched %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    get(`REG_STATUS, 32'h0);
    get(`REG_RESULT, 32'h0);
    get(`REG_ACC_HIGH, 32'h0);
    get(`REG_COMMAND, 32'h0);
    $display("reset test done");
    ctl = '{32'h0704, 32'h0D09, 32'h1C0A, 32'h1F1F, 32'h0500, 32'hFFFFE3E4};
    sa = 32'hA5A5C3AA;
    put(`REG_OPERAND_A, sa);
    for (i = 0; i < 6; i++) begin
      sb = ctl[i];
      put(`REG_OPERAND_B, sb);
      fieldOp(`OP_PULL_ZERO, pullExp(sa, sb, 1'b0));
      fieldOp(`OP_PULL_SIGN, pullExp(sa, sb, 1'b1));
    end
    $display("pull test done");
    ctl = '{32'h0703, 32'h5A5A0703, 32'hABCD1C0A, 32'h1000, 32'h0014, 32'h9ABC0F0C};
    for (j = 0; j < 2; j++) begin
      sa = j ? 32'h00008123 : 32'hFFFFFFFF;
      put(`REG_OPERAND_A, sa);
      for (i = 0; i < 6; i++) begin
        sb = ctl[i];
        put(`REG_OPERAND_B, sb);
        fieldOp(`OP_INSERT, insExp(sa, sb, 1'b0));
        fieldOp(`OP_INSERT_SIGN, insExp(sa, sb, 1'b1));
      end
    end
    $display("insert test done");
    // Sources are two distinct registers, so they never alias
    sa = 32'hA5A5C3AA;
    sb = 32'hC3AAA5A5;
    acc = 40'h9A12345678;
    put(`REG_OPERAND_A, sa);
    put(`REG_OPERAND_B, sb);
    put(`REG_ACC_LOW, acc[31:0]);
    put(`REG_ACC_HIGH, {24'h0, acc[39:32]});
    put(`REG_STATUS, 32'h5);
    for (k = 0; k < 2; k++) begin
      put(`REG_COMMAND, {1'b1, 27'h0, k ? `OP_MUX_LEFT : `OP_MUX_RIGHT});
      if (k) begin
        acc = {acc[38:0], sb[31]};
        acc = {acc[38:0], sa[31]};
        sa = sa << 1;
        sb = sb << 1;
      end else begin
        acc = {sa[0], acc[39:1]};
        acc = {sb[0], acc[39:1]};
        sa = sa >> 1;
        sb = sb >> 1;
      end
      get(`REG_OPERAND_A, sa);
      get(`REG_OPERAND_B, sb);
      get(`REG_ACC_LOW, acc[31:0]);
      get(`REG_ACC_HIGH, {24'h0, acc[39:32]});
      get(`REG_STATUS, 32'h5);
    end
    $display("interleave test done");
    // Short-word pull, marked interleave and unknown opcode are all refused
    ctl = '{32'h3, 32'hC0000005, 32'h80000007, 32'h0, 32'h0, 32'h0};
    put(`REG_STATUS, 32'h0);
    for (i = 0; i < 3; i++) begin
      put(`REG_COMMAND, ctl[i]);
      get(`REG_STATUS, 32'h100);
      get(`REG_RESULT, res);
      get(`REG_OPERAND_A, sa);
    end
    // A short, parallel-marked insert is still accepted
    res = insExp(sa, sb, 1'b0);
    put(`REG_COMMAND, 32'h40000001);
    get(`REG_RESULT, res);
    put(8'h40, 32'h1, 2'h3);
    get(8'h40, 32'h0, 2'h3);
    put(`REG_RESULT, 32'h1);
    get(`REG_RESULT, res);
    $display("refusal test done");
    summarize();
  end
endmodule // bit_field_unit_tb
